// ===== clock_timer_pkg.sv
`default_nettype none
package clock_timer_pkg;
   // System clock rate, 200 MHz
   localparam int          CLK_FREQ_MHZ   = 200;
   // Crystal edges per 256 Hz count step (32768 Hz source)
   localparam int          PRESCALE_DIV   = 128;
   localparam int          PRESCALE_W     = 7;
   // Upper-nibble hold limit, lower end of the allowed span
   localparam int          HOLD_TIME_US   = 480;
   localparam int          HOLD_CYCLES    = HOLD_TIME_US * CLK_FREQ_MHZ;
   localparam int          HOLD_W         = 17;
   // Register indices; byte address is four times the index
   localparam int          ADDR_W         = 18;
   localparam logic [15:0] IDX_CTRL       = 16'hff78;
   localparam logic [15:0] IDX_COUNT_LOW  = 16'hff79;
   localparam logic [15:0] IDX_COUNT_HIGH = 16'hff7a;
   localparam logic [15:0] IDX_MASK       = 16'hffe6;
   localparam logic [15:0] IDX_FLAGS      = 16'hfff6;
   // Control field positions
   localparam int          RUN_BIT        = 0;
   localparam int          CLR_BIT        = 1;
   // Counter bit positions of the interrupt taps
   localparam int          TAP_32HZ_BIT   = 2;
   localparam int          TAP_8HZ_BIT    = 4;
   localparam int          TAP_2HZ_BIT    = 6;
   localparam int          TAP_1HZ_BIT    = 7;
   // Reset values
   localparam logic [3:0]  NIBBLE_RST     = 4'h0;
   localparam logic        RUN_RST        = 1'b0;
   localparam logic [3:0]  MASK_RST       = 4'h0;
   localparam logic [3:0]  FLAG_RST       = 4'h0;
   // AXI responses
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   typedef enum logic [2:0] {
      SEL_NONE  = 3'h0,
      SEL_CTRL  = 3'h1,
      SEL_LOW   = 3'h2,
      SEL_HIGH  = 3'h3,
      SEL_MASK  = 3'h4,
      SEL_FLAGS = 3'h5
   } reg_sel_t;
endpackage
`default_nettype wire

// ===== clock_timer_with_hold.sv
// Register access over AXI4-Lite was left to the implementer.
`default_nettype none
// Function
// - An 8-bit up-counter steps on a prescaled crystal clock and all its bits are readable.
// - The low read word shows the 128..16 Hz bits, the high word the 8..1 Hz bits, in bits 3:0.
// - A carry out of the low nibble advances the high nibble as one count.
// - A low-nibble read holds the high nibble until a high read or a bounded time.
// - Falling edges of the 32, 8, 2 and 1 Hz bits are interrupt events.
// - Each such edge sets its own flag: bit 0 for 32 Hz up to bit 3 for 1 Hz.
// - Flags are set whatever the mask says.
// - One mask bit per frequency enables that interrupt.
// - The run bit starts and stops counting, keeping the count while stopped.
// - Writing one to the clear bit zeroes the count; it reads as zero.
// - Writing one to a flag bit clears it; zero leaves it.
// - Reset zeroes the count, the run bit, the masks and the flags.
module clock_timer_with_hold #(
   parameter int unsigned HOLD_CYCLES = clock_timer_pkg::HOLD_CYCLES
) (
   input  wire logic                               aclk,
   input  wire logic                               aresetn,
   input  wire logic                               crystal_osc_clock,
   input  wire logic [clock_timer_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                               s_axi_awvalid,
   output logic                                    s_axi_awready,
   input  wire logic [31:0]                        s_axi_wdata,
   input  wire logic [3:0]                         s_axi_wstrb,
   input  wire logic                               s_axi_wvalid,
   output logic                                    s_axi_wready,
   output logic [1:0]                              s_axi_bresp,
   output logic                                    s_axi_bvalid,
   input  wire logic                               s_axi_bready,
   input  wire logic [clock_timer_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                               s_axi_arvalid,
   output logic                                    s_axi_arready,
   output logic [31:0]                             s_axi_rdata,
   output logic [1:0]                              s_axi_rresp,
   output logic                                    s_axi_rvalid,
   input  wire logic                               s_axi_rready,
   output logic                                    irq
);
   // Register decode, shared by the read and write paths
   function automatic clock_timer_pkg::reg_sel_t reg_sel(
      input logic [clock_timer_pkg::ADDR_W-1:0] a
   );
      case (a[clock_timer_pkg::ADDR_W-1:2])
         clock_timer_pkg::IDX_CTRL:       reg_sel = clock_timer_pkg::SEL_CTRL;
         clock_timer_pkg::IDX_COUNT_LOW:  reg_sel = clock_timer_pkg::SEL_LOW;
         clock_timer_pkg::IDX_COUNT_HIGH: reg_sel = clock_timer_pkg::SEL_HIGH;
         clock_timer_pkg::IDX_MASK:       reg_sel = clock_timer_pkg::SEL_MASK;
         clock_timer_pkg::IDX_FLAGS:      reg_sel = clock_timer_pkg::SEL_FLAGS;
         default:                         reg_sel = clock_timer_pkg::SEL_NONE;
      endcase
   endfunction

   localparam logic [clock_timer_pkg::HOLD_W-1:0] HOLD_LAST =
      clock_timer_pkg::HOLD_W'(HOLD_CYCLES - 1);

   // Write channel state
   logic                               aw_full_q;
   logic [clock_timer_pkg::ADDR_W-1:0] aw_addr_q;
   logic                               w_full_q;
   logic [3:0]                         w_data_q;
   logic                               w_lane0_q;
   logic                               bvalid_q;
   logic [1:0]                         bresp_q;
   // Read channel state
   logic                               rvalid_q;
   logic [31:0]                        rdata_q;
   logic [1:0]                         rresp_q;
   // Timer state
   logic                               run_q;
   logic [3:0]                         mask_q;
   logic [3:0]                         count_low_q;
   logic [3:0]                         count_high_q;
   logic                               hold_q;
   logic [clock_timer_pkg::HOLD_W-1:0] hold_cnt_q;
   logic                               pend_q;
   logic                               clr_pend_q;
   logic                               irq_q;
   // Combinational helpers
   logic                               wr_go;
   clock_timer_pkg::reg_sel_t          wr_sel;
   clock_timer_pkg::reg_sel_t          rd_sel;
   logic                               ar_hs;
   logic                               clr_wr;
   logic [3:0]                         flag_clr;
   logic                               low_rd;
   logic                               high_rd;
   logic                               hold_end;
   logic                               cnt_tick;
   logic                               step;
   logic                               carry;
   logic                               carry_held;
   logic                               carry_pass;
   logic                               catch_up;
   logic [7:0]                         count;
   logic [3:0]                         taps;
   logic [3:0]                         flags;

   // Step pulse at 256 Hz derived from the crystal
   osc_tick_gen u_tick (
      .aclk              (aclk),
      .aresetn           (aresetn),
      .crystal_osc_clock (crystal_osc_clock),
      .tick              (cnt_tick)
   );

   // Write address and data are taken in either order
   assign s_axi_awready = ~aw_full_q;
   assign s_axi_wready  = ~w_full_q;
   assign wr_go         = aw_full_q & w_full_q & ~bvalid_q;
   assign wr_sel        = reg_sel(aw_addr_q);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         aw_addr_q <= '0;
      end else if (s_axi_awvalid && !aw_full_q) begin
         aw_full_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_full_q <= 1'b0;
      end
   end

   // Only lane 0 carries register bits; upper lanes are ignored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full_q  <= 1'b0;
         w_data_q  <= 4'h0;
         w_lane0_q <= 1'b0;
      end else if (s_axi_wvalid && !w_full_q) begin
         w_full_q  <= 1'b1;
         w_data_q  <= s_axi_wdata[3:0];
         w_lane0_q <= s_axi_wstrb[0];
      end else if (wr_go) begin
         w_full_q <= 1'b0;
      end
   end

   // Write response; unmapped addresses answer with a slave error
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= clock_timer_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q  <= (wr_sel == clock_timer_pkg::SEL_NONE) ?
                     clock_timer_pkg::RESP_SLVERR : clock_timer_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;

   // Write side effects
   assign clr_wr   = wr_go && wr_sel == clock_timer_pkg::SEL_CTRL && w_lane0_q
                     && w_data_q[clock_timer_pkg::CLR_BIT];
   assign flag_clr = (wr_go && wr_sel == clock_timer_pkg::SEL_FLAGS && w_lane0_q) ?
                     w_data_q : 4'h0;

   // Run bit and mask register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_q  <= clock_timer_pkg::RUN_RST;
         mask_q <= clock_timer_pkg::MASK_RST;
      end else if (wr_go && w_lane0_q) begin
         if (wr_sel == clock_timer_pkg::SEL_CTRL) begin
            run_q <= w_data_q[clock_timer_pkg::RUN_BIT];
         end
         if (wr_sel == clock_timer_pkg::SEL_MASK) begin
            mask_q <= w_data_q;
         end
      end
   end

   // Read path; one read at a time, answered the cycle after arvalid
   assign s_axi_arready = ~rvalid_q;
   assign ar_hs         = s_axi_arvalid & ~rvalid_q;
   assign rd_sel        = reg_sel(s_axi_araddr);
   assign low_rd        = ar_hs && rd_sel == clock_timer_pkg::SEL_LOW;
   assign high_rd       = ar_hs && rd_sel == clock_timer_pkg::SEL_HIGH;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0;
         rresp_q  <= clock_timer_pkg::RESP_OKAY;
      end else if (ar_hs) begin
         rvalid_q <= 1'b1;
         rresp_q  <= clock_timer_pkg::RESP_OKAY;
         rdata_q  <= 32'h0;
         case (rd_sel)
            clock_timer_pkg::SEL_CTRL:  rdata_q[clock_timer_pkg::RUN_BIT] <= run_q;
            clock_timer_pkg::SEL_LOW:   rdata_q[3:0] <= count_low_q;
            clock_timer_pkg::SEL_HIGH:  rdata_q[3:0] <= count_high_q;
            clock_timer_pkg::SEL_MASK:  rdata_q[3:0] <= mask_q;
            clock_timer_pkg::SEL_FLAGS: rdata_q[3:0] <= flags;
            default:                    rresp_q <= clock_timer_pkg::RESP_SLVERR;
         endcase
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;

   // Hold window: opened by a low read, closed by a high read or timeout
   assign hold_end = hold_q && (high_rd || hold_cnt_q == HOLD_LAST);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_q     <= 1'b0;
         hold_cnt_q <= '0;
      end else begin
         if (clr_wr) begin
            hold_q <= 1'b0;
         end else if (low_rd) begin
            hold_q <= 1'b1;
         end else if (hold_end) begin
            hold_q <= 1'b0;
         end
         if (low_rd) begin
            hold_cnt_q <= '0;
         end else if (hold_q) begin
            hold_cnt_q <= hold_cnt_q + 1'b1;
         end
      end
   end

   // Carry handling; a blocked carry is kept and applied when the hold ends
   assign step       = cnt_tick & run_q;
   assign carry      = step && count_low_q == 4'hf;
   assign carry_held = carry & hold_q & ~hold_end;
   assign carry_pass = carry & ~carry_held;
   assign catch_up   = hold_end & pend_q;

   // Lower nibble, 128..16 Hz stages
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_low_q <= clock_timer_pkg::NIBBLE_RST;
      end else if (clr_wr) begin
         count_low_q <= clock_timer_pkg::NIBBLE_RST;
      end else if (step) begin
         count_low_q <= count_low_q + 4'h1;
      end
   end

   // Upper nibble, 8..1 Hz stages; pending carry prevents losing a count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_high_q <= clock_timer_pkg::NIBBLE_RST;
      end else if (clr_wr) begin
         count_high_q <= clock_timer_pkg::NIBBLE_RST;
      end else begin
         count_high_q <= count_high_q + {3'h0, carry_pass} + {3'h0, catch_up};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_q <= 1'b0;
      end else if (clr_wr) begin
         pend_q <= 1'b0;
      end else if (carry_held) begin
         pend_q <= 1'b1;
      end else if (hold_end) begin
         pend_q <= 1'b0;
      end
   end

   // Edges made by a clear are not time events, so they are masked
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clr_pend_q <= 1'b0;
      end else begin
         clr_pend_q <= clr_wr;
      end
   end

   assign count = {count_high_q, count_low_q};
   assign taps  = {count[clock_timer_pkg::TAP_1HZ_BIT], count[clock_timer_pkg::TAP_2HZ_BIT],
                   count[clock_timer_pkg::TAP_8HZ_BIT], count[clock_timer_pkg::TAP_32HZ_BIT]};

   // Sticky flags, one per tap
   edge_flag_bank u_flags (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .taps     (taps),
      .suppress (clr_pend_q),
      .clr_bits (flag_clr),
      .flags    (flags)
   );

   // Level interrupt, one cycle behind the flags
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(flags & mask_q);
      end
   end

   assign irq = irq_q;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   low_carry_a:
   assert property (step && count_low_q == 4'hf && !hold_q && !clr_wr
                    |=> count_high_q == $past(count_high_q) + 4'h1 && count_low_q == 4'h0)
      else $error("carry did not reach upper nibble");

   hold_block_a:
   assert property (hold_q && !hold_end && !clr_wr |=> count_high_q == $past(count_high_q))
      else $error("upper nibble moved during hold");

   hold_limit_a:
   assert property (hold_q |-> hold_cnt_q <= HOLD_LAST)
      else $error("hold outlived its limit");

   high_release_a:
   assert property (hold_q && high_rd |=> !hold_q)
      else $error("high read did not end hold");

   stop_keep_a:
   assert property (!run_q && !clr_wr |=> count_low_q == $past(count_low_q))
      else $error("count moved while stopped");

   clear_zero_a:
   assert property (clr_wr |=> count == 8'h00 && !hold_q)
      else $error("clear did not zero count");

   fall32_flag_a:
   assert property (!clr_pend_q && $fell(taps[0]) |=> flags[0])
      else $error("32 Hz flag not set");

   fall1_flag_a:
   assert property (!clr_pend_q && $fell(taps[3]) && !mask_q[3] |=> flags[3])
      else $error("masked 1 Hz flag not set");

   flag_clear_a:
   assert property (flag_clr[1] && !(taps[1] == 1'b0 && $past(taps[1])) |=> !flags[1])
      else $error("flag not cleared by one");

   irq_level_a:
   assert property (##1 irq == $past(|(flags & mask_q)))
      else $error("interrupt level wrong");

   low_read_a:
   assert property (low_rd |=> s_axi_rvalid && s_axi_rdata == {28'h0, $past(count_low_q)})
      else $error("low nibble read wrong");
endmodule
`default_nettype wire

// ===== clock_timer_with_hold_test.sv
`default_nettype none
module clock_timer_with_hold_test;
   timeunit 1ns;
   timeprecision 100ps;

   // Short hold so both hold exits fit in a few count steps
   localparam int          HOLD  = 400;
   localparam logic [15:0] CTRL  = clock_timer_pkg::IDX_CTRL;
   localparam logic [15:0] LOW   = clock_timer_pkg::IDX_COUNT_LOW;
   localparam logic [15:0] HIGH  = clock_timer_pkg::IDX_COUNT_HIGH;
   localparam logic [15:0] MASK  = clock_timer_pkg::IDX_MASK;
   localparam logic [15:0] FLAGS = clock_timer_pkg::IDX_FLAGS;
   localparam logic [1:0]  OKAY  = clock_timer_pkg::RESP_OKAY;

   logic        aclk;
   logic        aresetn;
   logic        crystal_osc_clock;
   logic [17:0] s_axi_awaddr;
   logic        s_axi_awvalid;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_wvalid;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready;
   logic [17:0] s_axi_araddr;
   logic        s_axi_arvalid;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready;
   logic        irq;
   logic [31:0] rd_data;
   logic [1:0]  rd_resp;
   logic [1:0]  wr_resp;
   logic [3:0]  l;
   logic [3:0]  h0;
   logic [3:0]  nxt;
   logic [15:0] regs [5];
   int          errors;
   int          comparisons;

   clock_timer_with_hold #(
      .HOLD_CYCLES(HOLD)
   ) dut_u (
      .aclk(aclk), .aresetn(aresetn), .crystal_osc_clock(crystal_osc_clock),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq)
   );

   // 200 MHz system clock
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   // Fast crystal; half period above the system period so no edge is lost
   initial begin
      crystal_osc_clock = 1'b0;
      forever #5.5 crystal_osc_clock = ~crystal_osc_clock;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic complete_run;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Handshakes judged at the falling edge, so the rising edge sees the same
   task automatic wr(input logic [15:0] idx, input logic [3:0] val);
      int   n;
      logic a;
      logic w;
      logic b;
      @(posedge aclk);
      s_axi_awaddr  <= {idx, 2'b00};
      s_axi_wdata   <= {28'h0, val};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      n = 0;
      do begin
         @(negedge aclk);
         a = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         wr_resp = s_axi_bresp;
         @(posedge aclk);
         if (a)
            s_axi_awvalid <= 1'b0;
         if (w)
            s_axi_wvalid <= 1'b0;
         n++;
      end while (b !== 1'b1 && n < 100);
      s_axi_bready <= 1'b0;
      check("write answer", b, 1'b1);
   endtask

   task automatic rd(input logic [15:0] idx);
      int   n;
      logic a;
      logic r;
      @(posedge aclk);
      s_axi_araddr  <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      n = 0;
      do begin
         @(negedge aclk);
         a = s_axi_arvalid && s_axi_arready;
         r = s_axi_rvalid;
         rd_data = s_axi_rdata;
         rd_resp = s_axi_rresp;
         @(posedge aclk);
         if (a)
            s_axi_arvalid <= 1'b0;
         n++;
      end while (r !== 1'b1 && n < 100);
      s_axi_rready <= 1'b0;
      check("read answer", r, 1'b1);
   endtask

   // Bounded poll until the nibble equals, or differs from, v
   task automatic poll(input logic [15:0] idx, input logic [3:0] v, input logic eq);
      int n;
      n = 0;
      do begin
         rd(idx);
         n++;
      end while (((rd_data[3:0] === v) != eq) && n < 40000);
      check("poll bound", n < 40000, 1'b1);
   endtask

   // irq is registered after the flag or mask change; let it land
   task automatic ck_irq(input logic e);
      repeat (3) @(negedge aclk);
      check("irq", irq, e);
   endtask

   // Whole run, 1 Hz sweep included, is near 87k cycles
   initial begin
      repeat (97000) @(posedge aclk);
      errors++;
      complete_run();
   end

   initial begin
      errors = 0;
      comparisons = 0;
      regs = '{CTRL, LOW, HIGH, MASK, FLAGS};
      aresetn = 1'b0;
      s_axi_awaddr = 18'h0;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 18'h0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         rd(regs[i]);
         check("reset value", rd_data, 32'h0);
         check("reset rresp", rd_resp, OKAY);
      end
      ck_irq(1'b0);
      // Unmapped place answers with an error and no data
      rd(16'hff7b);
      check("unmapped rresp", rd_resp, clock_timer_pkg::RESP_SLVERR);
      check("unmapped rdata", rd_data, 32'h0);
      wr(16'hff7b, 4'h1);
      check("unmapped bresp", wr_resp, clock_timer_pkg::RESP_SLVERR);
      // Stopped counter holds zero and ignores writes to the count
      wr(LOW, 4'h5);
      check("count write bresp", wr_resp, OKAY);
      repeat (700) @(posedge aclk);
      rd(LOW);
      check("stopped low", rd_data, 32'h0);
      wr(CTRL, 4'h1);
      rd(CTRL);
      check("run bit", rd_data, 32'h1);
      poll(FLAGS, 4'h1, 1'b1);
      rd(LOW);
      check("32 Hz fall count", rd_data, 32'h8);
      ck_irq(1'b0);
      wr(MASK, 4'he);
      ck_irq(1'b0);
      wr(MASK, 4'h1);
      rd(MASK);
      check("mask readback", rd_data, 32'h1);
      // A write with lane 0 off is answered but leaves the mask alone
      s_axi_wstrb <= 4'he;
      wr(MASK, 4'h0);
      s_axi_wstrb <= 4'hf;
      check("lane off bresp", wr_resp, OKAY);
      rd(MASK);
      check("mask lane off", rd_data, 32'h1);
      ck_irq(1'b1);
      wr(FLAGS, 4'h0);
      rd(FLAGS);
      check("flags after zero", rd_data, 32'h1);
      wr(FLAGS, 4'h1);
      rd(FLAGS);
      check("flags after clear", rd_data, 32'h0);
      ck_irq(1'b0);
      // Stop keeps the count, run resumes from it
      wr(CTRL, 4'h0);
      rd(LOW);
      l = rd_data[3:0];
      repeat (700) @(posedge aclk);
      rd(LOW);
      check("held while stopped", rd_data[3:0], l);
      wr(CTRL, 4'h1);
      poll(LOW, l, 1'b0);
      nxt = l + 4'h1;
      check("resume step", rd_data[3:0], nxt);
      // Clear in run restarts at once; prescaler phase may allow one step
      wr(CTRL, 4'h3);
      rd(LOW);
      check("cleared low", rd_data < 2, 1'b1);
      rd(CTRL);
      check("clear bit reads", rd_data, 32'h1);
      wr(CTRL, 4'h0);
      wr(CTRL, 4'h2);
      repeat (700) @(posedge aclk);
      rd(LOW);
      check("stop clear low", rd_data, 32'h0);
      rd(HIGH);
      check("stop clear high", rd_data, 32'h0);
      // Carry after a low read waits for the high read, or for the time limit
      wr(CTRL, 4'h1);
      for (int k = 0; k < 2; k++) begin
         do begin
            rd(HIGH);
            h0 = rd_data[3:0];
            rd(LOW);
         end while (rd_data[3:0] !== 4'hf);
         nxt = h0 + 4'h1;
         repeat (k == 0 ? 330 : 450) @(posedge aclk);
         rd(HIGH);
         check("high after wait", rd_data[3:0], k == 0 ? h0 : nxt);
         rd(HIGH);
         check("high released", rd_data[3:0], nxt);
      end
      // Full sweep: each tap sets its own flag, only 1 Hz unmasked
      wr(MASK, 4'h8);
      wr(CTRL, 4'h3);
      wr(FLAGS, 4'hf);
      poll(HIGH, 4'h3, 1'b1);
      rd(FLAGS);
      check("flags at 48", rd_data, 32'h3);
      ck_irq(1'b0);
      poll(HIGH, 4'h9, 1'b1);
      rd(FLAGS);
      check("flags at 144", rd_data, 32'h7);
      poll(HIGH, 4'hf, 1'b1);
      poll(HIGH, 4'h0, 1'b1);
      rd(FLAGS);
      check("flags after wrap", rd_data, 32'hf);
      ck_irq(1'b1);
      wr(MASK, 4'h0);
      ck_irq(1'b0);
      complete_run();
   end
endmodule
`default_nettype wire

// ===== edge_flag_bank.sv
`default_nettype none
module edge_flag_bank (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [3:0] taps,
   input  wire logic       suppress,
   input  wire logic [3:0] clr_bits,
   output logic      [3:0] flags
);
   logic [3:0] prev_q;
   logic [3:0] flag_q;

   genvar k;
   generate
      for (k = 0; k < 4; k++) begin : g_flag
         // Falling tap sets the flag; set beats a same-cycle clear
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               prev_q[k] <= 1'b0;
               flag_q[k] <= clock_timer_pkg::FLAG_RST[k];
            end else begin
               prev_q[k] <= taps[k];
               flag_q[k] <= (flag_q[k] & ~clr_bits[k])
                            | (prev_q[k] & ~taps[k] & ~suppress);
            end
         end
      end
   endgenerate

   assign flags = flag_q;
endmodule
`default_nettype wire

// ===== osc_tick_gen.sv
`default_nettype none
module osc_tick_gen (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic crystal_osc_clock,
   output logic      tick
);
   logic [1:0]                                    sync_q;
   logic                                          prev_q;
   logic [clock_timer_pkg::PRESCALE_W-1:0]        div_q;
   logic                                          tick_q;
   logic                                          osc_rise;

   // Crystal is asynchronous; two stages before anything looks at it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_q <= 2'h0;
         prev_q <= 1'b0;
      end else begin
         sync_q <= {sync_q[0], crystal_osc_clock};
         prev_q <= sync_q[1];
      end
   end

   assign osc_rise = sync_q[1] & ~prev_q;

   // Prescaler: one step pulse per PRESCALE_DIV crystal edges
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= 1'b0;
         if (osc_rise) begin
            if (div_q == clock_timer_pkg::PRESCALE_W'(clock_timer_pkg::PRESCALE_DIV - 1)) begin
               div_q  <= '0;
               tick_q <= 1'b1;
            end else begin
               div_q <= div_q + 1'b1;
            end
         end
      end
   end

   assign tick = tick_q;
endmodule
`default_nettype wire
